/* verilog/pid_pkg.sv */
package pid_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] ACT_OFS = 8'h00;   // Action select code
    localparam logic [7:0] SETP_OFS = 8'h04;  // Set point, 0.1 % units
    localparam logic [7:0] UPLIM_OFS = 8'h08; // Upper limit, 0.1 % units
    localparam logic [7:0] LOLIM_OFS = 8'h0C; // Lower limit, 0.1 % units
    localparam logic [7:0] GAIN_OFS = 8'h10;  // kp [7:0] ki [15:8] kd [23:16]
    localparam logic [7:0] INFN_OFS = 8'h20;  // First input function word
    localparam logic [7:0] OUTFN_OFS = 8'h40; // First output function word
    localparam logic [7:0] NETIN_OFS = 8'h50; // Network-driven input bits
    localparam logic [7:0] STAT_OFS = 8'h60;  // Live state, read only
    localparam logic [7:0] SPEED_OFS = 8'h64; // Speed command, read only
    localparam logic [7:0] IRQST_OFS = 8'h68; // Sticky events, read clears
    localparam logic [7:0] IRQMSK_OFS = 8'h6C; // Interrupt mask

    // Reset values
    localparam logic [7:0] ACT_RST = 8'h00;      // Ordinary speed control
    localparam logic [13:0] NOFUNC = 14'h270F;   // 9999, function off
    localparam logic [7:0] GAIN_RST = 8'h00;     // Term disabled
    localparam logic [7:0] FN_RST = 8'h00;       // No function assigned

    // Action select codes
    localparam logic [7:0] ACT_AN_REV = 8'h14;   // 20
    localparam logic [7:0] ACT_AN_FWD = 8'h15;   // 21
    localparam logic [7:0] ACT_DV_REV = 8'h32;   // 50
    localparam logic [7:0] ACT_DV_FWD = 8'h33;   // 51
    localparam logic [7:0] ACT_FB_REV = 8'h3C;   // 60
    localparam logic [7:0] ACT_FB_FWD = 8'h3D;   // 61

    // Terminal function codes
    localparam logic [7:0] FN_LOOPSEL = 8'h0E;   // 14 on an input
    localparam logic [7:0] FN_LOWER = 8'h0E;     // 14 on an output
    localparam logic [7:0] FN_UPPER = 8'h0F;     // 15
    localparam logic [7:0] FN_DIR = 8'h10;       // 16
    localparam logic [7:0] FN_ACTIVE = 8'h2F;    // 47
    localparam logic [7:0] FN_NEG = 8'h64;       // 100, negative logic

    // Loop update period
    localparam int CLK_MHZ = 25;
    localparam int SAMPLE_TIME_US = 1000;
    localparam int SAMPLE_CYCLES = SAMPLE_TIME_US * CLK_MHZ;

    // Interrupt status bits
    localparam int EV_ACTIVE = 0;
    localparam int EV_UPPER = 1;
    localparam int EV_LOWER = 2;
endpackage

/* verilog/pid_speed_regulator.sv */
`timescale 1ns/10ps
// What this block does
// [RL1] Speed equals sum of enabled terms
// [RL2] Derivative term follows deviation change
// [RL3] Reverse: positive deviation raises speed
// [RL4] Forward: negative deviation raises speed
// [RL5] Loop only for codes 20,21,50,51,60,61
// [RL6] Code 0 or select off: plain speed
// [RL7] Input function 14 gates the loop
// [RL8] No select input: code alone enables
// [RL9] Network bit acts as input terminal
// [RL10] Codes 20/21: analog or parameter set point
// [RL11] Codes 50/51: deviation from fieldbus
// [RL12] Codes 60/61: both values from fieldbus
// [RL13] Upper flag: measured above upper limit
// [RL14] Lower flag: measured below lower limit
// [RL15] Direction high only for forward rotation
// [RL16] Active output on while loop runs
// [RL17] Codes 100 up invert the terminal
// [RL18] Even code reverse, odd code forward
module pid_speed_regulator #(
    parameter int N_IN = 7,           // Input terminals
    parameter int N_OUT = 3,          // Output terminals
    parameter int SAMPLE_CYC = pid_pkg::SAMPLE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_IN-1:0] in_terminals,
    input wire logic [9:0] analog_setpoint,
    input wire logic [9:0] analog_measured,
    input wire logic [9:0] fb_setpoint,
    input wire logic [9:0] fb_measured,
    input wire logic signed [11:0] fb_deviation,
    input wire logic [15:0] normal_speed,
    input wire logic run_forward,
    output logic [N_OUT-1:0] out_terminals,
    output logic [15:0] speed_cmd,
    output logic pid_active,
    output logic irq
);
    // Software settings
    logic [7:0] act_q;                    // Action select code
    logic [13:0] setp_q;                  // Set point parameter
    logic [13:0] uplim_q;                 // Upper limit setting
    logic [13:0] lolim_q;                 // Lower limit setting
    logic [23:0] gain_q;                  // Three gains, zero turns off
    logic [7:0] infn_q [N_IN];            // Input function settings
    logic [7:0] outfn_q [N_OUT];          // Output function settings
    logic [N_IN-1:0] netin_q;             // Bits written over network
    logic [2:0] irq_st_q;                 // Sticky events
    logic [2:0] irq_msk_q;                // Event mask
    // Loop state
    logic signed [23:0] integ_q;          // Integral accumulator
    logic signed [11:0] dev_prev_q;       // Deviation of last sample
    logic [$clog2(SAMPLE_CYC+1)-1:0] tick_cnt_q;
    logic upper_q;                        // Upper flag state
    logic lower_q;                        // Lower flag state

    // Output function decode, used for every terminal and every flag
    function automatic logic [7:0] base_fn(input logic [7:0] fn);
        base_fn = (fn >= pid_pkg::FN_NEG) ? 8'(fn - pid_pkg::FN_NEG) : fn;
    endfunction

    // Bus phases
    wire setup_ph = psel && !penable;
    wire wr_ok = psel && penable && pready && pwrite;
    wire rd_ok = psel && penable && pready && !pwrite;

    // Mode decode
    wire code_an = (act_q == pid_pkg::ACT_AN_REV)
        || (act_q == pid_pkg::ACT_AN_FWD);
    wire code_dv = (act_q == pid_pkg::ACT_DV_REV)
        || (act_q == pid_pkg::ACT_DV_FWD);
    wire code_fb = (act_q == pid_pkg::ACT_FB_REV)
        || (act_q == pid_pkg::ACT_FB_FWD);
    wire code_ok = code_an || code_dv || code_fb;                 // RL5
    wire fwd_act = act_q[0];                                      // RL18

    // Loop select: any terminal given function 14, pin or network bit
    logic [N_IN-1:0] sel_map;
    logic [N_IN-1:0] sel_on;
    for (genvar gi = 0; gi < N_IN; gi++) begin : g_in
        assign sel_map[gi] = (infn_q[gi] == pid_pkg::FN_LOOPSEL);
        assign sel_on[gi] = sel_map[gi]
            && (in_terminals[gi] || netin_q[gi]);                 // RL9
    end
    wire sel_assigned = |sel_map;
    // Without an assigned terminal the code alone is enough
    wire loop_run = code_ok
        && (!sel_assigned || (|sel_on));                      // RL6 RL7 RL8

    // Sources
    wire [9:0] sp_sel = code_fb ? fb_setpoint                     // RL12
        : (setp_q == pid_pkg::NOFUNC) ? analog_setpoint           // RL10
        : setp_q[9:0];
    wire [9:0] pv_sel = code_fb ? fb_measured : analog_measured;  // RL12
    wire signed [11:0] dev_loc = $signed({2'b00, sp_sel})
        - $signed({2'b00, pv_sel});
    wire signed [11:0] dev_raw = code_dv ? fb_deviation : dev_loc; // RL11
    // Forward action flips the sign so the same math raises speed
    wire signed [11:0] dev = fwd_act ? 12'(-dev_raw) : dev_raw; // RL3 RL4

    // Terms, gains unsigned so sign follows deviation
    wire signed [20:0] p_term = dev * $signed({1'b0, gain_q[7:0]});
    wire signed [20:0] i_step = dev * $signed({1'b0, gain_q[15:8]});
    wire signed [12:0] d_dev = 13'(dev) - 13'(dev_prev_q);        // RL2
    wire signed [21:0] d_term = d_dev * $signed({1'b0, gain_q[23:16]});
    wire signed [24:0] i_next = 25'(integ_q) + 25'(i_step);
    wire signed [23:0] i_sat = (i_next > 25'sh07FFFFF) ? 24'sh7FFFFF
        : (i_next < -25'sh0800000) ? -24'sh800000 : 24'(i_next);
    wire signed [25:0] u_sum = 26'(p_term) + 26'(integ_q)
        + 26'(d_term);                                            // RL1
    wire [15:0] u_clamp = (u_sum < 0) ? 16'h0000
        : (u_sum > 26'sh000FFFF) ? 16'hFFFF : u_sum[15:0];
    wire tick = (tick_cnt_q == 0);

    // Limit flags, only in local or fieldbus measured modes
    wire lim_mode = code_an || code_fb;
    logic [N_OUT-1:0] has_up;
    logic [N_OUT-1:0] has_lo;
    logic [N_OUT-1:0] term_d;
    wire upper_d = lim_mode && (uplim_q != pid_pkg::NOFUNC)
        && (|has_up) && ({4'h0, pv_sel} > uplim_q);               // RL13
    wire lower_d = lim_mode && (lolim_q != pid_pkg::NOFUNC)
        && (|has_lo) && ({4'h0, pv_sel} < lolim_q);               // RL14

    // Terminal routing
    for (genvar go = 0; go < N_OUT; go++) begin : g_out
        wire [7:0] bf = base_fn(outfn_q[go]);
        wire neg = (outfn_q[go] >= pid_pkg::FN_NEG);
        wire lvl = (bf == pid_pkg::FN_UPPER) ? upper_q
            : (bf == pid_pkg::FN_LOWER) ? lower_q
            : (bf == pid_pkg::FN_DIR) ? run_forward               // RL15
            : (bf == pid_pkg::FN_ACTIVE) ? pid_active : 1'b0;     // RL16
        assign has_up[go] = (bf == pid_pkg::FN_UPPER);
        assign has_lo[go] = (bf == pid_pkg::FN_LOWER);
        assign term_d[go] = lvl ^ neg;                            // RL17
    end

    // Read mux
    logic [31:0] rd_d;
    logic rd_err;
    always_comb begin
        rd_d = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr >= pid_pkg::INFN_OFS
            && paddr < 8'(pid_pkg::INFN_OFS + 8'(4 * N_IN))) begin
            rd_d = {24'h0, infn_q[3'(8'(paddr - pid_pkg::INFN_OFS) >> 2)]};
        end else if (paddr >= pid_pkg::OUTFN_OFS
            && paddr < 8'(pid_pkg::OUTFN_OFS + 8'(4 * N_OUT))) begin
            rd_d = {24'h0,
                outfn_q[2'(8'(paddr - pid_pkg::OUTFN_OFS) >> 2)]};
        end else begin
            unique case (paddr)
                pid_pkg::ACT_OFS: rd_d = {24'h0, act_q};
                pid_pkg::SETP_OFS: rd_d = {18'h0, setp_q};
                pid_pkg::UPLIM_OFS: rd_d = {18'h0, uplim_q};
                pid_pkg::LOLIM_OFS: rd_d = {18'h0, lolim_q};
                pid_pkg::GAIN_OFS: rd_d = {8'h0, gain_q};
                pid_pkg::NETIN_OFS: rd_d = 32'(netin_q);
                pid_pkg::STAT_OFS: rd_d = {28'h0, run_forward, lower_q,
                    upper_q, pid_active};
                pid_pkg::SPEED_OFS: rd_d = {16'h0, speed_cmd};
                pid_pkg::IRQST_OFS: rd_d = {29'h0, irq_st_q};
                pid_pkg::IRQMSK_OFS: rd_d = {29'h0, irq_msk_q};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // Bus answer: ready in the cycle after setup, data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            prdata <= setup_ph && !pwrite ? rd_d : 32'h0000_0000;
            pslverr <= setup_ph && rd_err;
        end
    end

    // Writable settings; unmapped writes are dropped with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= pid_pkg::ACT_RST;
            setp_q <= pid_pkg::NOFUNC;
            uplim_q <= pid_pkg::NOFUNC;
            lolim_q <= pid_pkg::NOFUNC;
            gain_q <= {3{pid_pkg::GAIN_RST}};
            netin_q <= '0;
            irq_msk_q <= 3'h0;
        end else if (wr_ok) begin
            unique case (paddr)
                pid_pkg::ACT_OFS: act_q <= pwdata[7:0];
                pid_pkg::SETP_OFS: setp_q <= pwdata[13:0];
                pid_pkg::UPLIM_OFS: uplim_q <= pwdata[13:0];
                pid_pkg::LOLIM_OFS: lolim_q <= pwdata[13:0];
                pid_pkg::GAIN_OFS: gain_q <= pwdata[23:0];
                pid_pkg::NETIN_OFS: netin_q <= pwdata[N_IN-1:0];
                pid_pkg::IRQMSK_OFS: irq_msk_q <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Terminal function words, one per terminal
    for (genvar gw = 0; gw < N_IN; gw++) begin : g_infn
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                infn_q[gw] <= pid_pkg::FN_RST;
            end else if (wr_ok
                && paddr == 8'(pid_pkg::INFN_OFS + 4 * gw)) begin
                infn_q[gw] <= pwdata[7:0];
            end
        end
    end
    for (genvar gv = 0; gv < N_OUT; gv++) begin : g_outfn
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                outfn_q[gv] <= pid_pkg::FN_RST;
            end else if (wr_ok
                && paddr == 8'(pid_pkg::OUTFN_OFS + 4 * gv)) begin
                outfn_q[gv] <= pwdata[7:0];
            end
        end
    end

    // Sample timer; a long period keeps the derivative meaningful
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= ($bits(tick_cnt_q))'(SAMPLE_CYC - 1);
        end else begin
            tick_cnt_q <= tick_cnt_q - 1'b1;
        end
    end

    // Loop state; leaving the loop clears history so re-entry starts at 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            integ_q <= '0;
            dev_prev_q <= '0;
        end else if (!loop_run) begin
            integ_q <= '0;                                        // RL6
            dev_prev_q <= '0;
        end else if (tick) begin
            integ_q <= i_sat;
            dev_prev_q <= dev;                                    // RL2
        end
    end

    // Speed command: loop output while running, ordinary speed otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_cmd <= 16'h0000;
            pid_active <= 1'b0;
        end else begin
            pid_active <= loop_run;                               // RL16
            if (!loop_run) begin
                speed_cmd <= normal_speed;                        // RL6
            end else if (tick) begin
                speed_cmd <= u_clamp;                             // RL1
            end
        end
    end

    // Flags and terminals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_q <= 1'b0;
            lower_q <= 1'b0;
            out_terminals <= '0;
        end else begin
            upper_q <= upper_d;                                   // RL13
            lower_q <= lower_d;                                   // RL14
            out_terminals <= term_d;                              // RL17
        end
    end

    // Events; a new event beats a read clear in the same cycle
    wire [2:0] ev = {lower_d && !lower_q, upper_d && !upper_q,
        loop_run && !pid_active};
    wire rd_clr = rd_ok && (paddr == pid_pkg::IRQST_OFS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_st_q <= (rd_clr ? 3'h0 : irq_st_q) | ev;
            irq <= |(((rd_clr ? 3'h0 : irq_st_q) | ev) & irq_msk_q);
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_loop_on;
        loop_run ##1 loop_run;
    endsequence

    a_code_gate: assert property (pid_active |-> $past(code_ok)) // RL5
        else $error("loop active with invalid code");
    a_plain_speed: assert property (!loop_run |=>                 // RL6
        speed_cmd == $past(normal_speed) && integ_q == 0)
        else $error("plain speed not passed through");
    a_select_off: assert property (code_ok && sel_assigned        // RL7
        && !(|sel_on) |=> !pid_active)
        else $error("loop ran with select off");
    a_no_select: assert property (code_ok && !sel_assigned       // RL8
        |=> pid_active)
        else $error("code alone did not start loop");
    a_reverse_raise: assert property (s_loop_on ##0 tick && !fwd_act
        && dev_raw > 0 && gain_q[23:8] == 0 && gain_q[7:0] != 0
        |=> speed_cmd != 0) // RL3
        else $error("reverse action did not raise speed");
    a_forward_raise: assert property (s_loop_on ##0 tick && fwd_act
        && dev_raw < 0 && gain_q[23:8] == 0 && gain_q[7:0] != 0
        |=> speed_cmd != 0) // RL4
        else $error("forward action did not raise speed");
    a_fb_deviation: assert property (code_dv |->                  // RL11
        dev_raw == fb_deviation)
        else $error("deviation not taken from fieldbus");
    a_upper_flag: assert property (upper_d |=> upper_q ##0        // RL13
        $past({4'h0, pv_sel}) > $past(uplim_q))
        else $error("upper flag wrong");
    a_lower_gate: assert property (lolim_q == pid_pkg::NOFUNC     // RL14
        |=> !lower_q)
        else $error("lower flag set with limit off");
    a_active_out: assert property (loop_run ##1 loop_run          // RL16
        |-> pid_active)
        else $error("active output missing");
endmodule

/* sim/pid_field_model.sv */
`timescale 1ns/10ps
// Far side of the regulator: process detector, set point source,
// fieldbus master and the drive's own speed path
module pid_field_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] sp_req,
    input wire logic [9:0] pv_req,
    input wire logic [9:0] fsp_req,
    input wire logic [9:0] fpv_req,
    input wire logic signed [11:0] dev_req,
    input wire logic [15:0] spd_req,
    input wire logic fwd_req,
    output logic [9:0] analog_setpoint,
    output logic [9:0] analog_measured,
    output logic [9:0] fb_setpoint,
    output logic [9:0] fb_measured,
    output logic signed [11:0] fb_deviation,
    output logic [15:0] normal_speed,
    output logic run_forward
);
    // Full scale of the detector and set point range, 100.0 %
    localparam logic [9:0] FULL = 10'h3E8;

    // Values change just after an edge, like real sampled sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_setpoint <= 10'h000;
            analog_measured <= 10'h000;
            fb_setpoint <= 10'h000;
            fb_measured <= 10'h000;
            fb_deviation <= 12'sh000;
            normal_speed <= 16'h0000;
            run_forward <= 1'b0;
        end else begin
            // The analog front end saturates at full scale
            analog_setpoint <= (sp_req > FULL) ? FULL : sp_req;
            analog_measured <= (pv_req > FULL) ? FULL : pv_req;
            fb_setpoint <= fsp_req;
            fb_measured <= fpv_req;
            fb_deviation <= dev_req;
            normal_speed <= spd_req;
            run_forward <= fwd_req;
        end
    end
endmodule

/* sim/pid_speed_regulator_tb.sv */
`timescale 1ns/10ps
module pid_speed_regulator_tb;
    localparam int SC = 4; // Short loop period keeps the run brief
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] in_terminals = 7'h00;
    logic [9:0] sp_q = 10'h000, pv_q = 10'h000;
    logic [9:0] fsp_q = 10'h000, fpv_q = 10'h000;
    logic signed [11:0] dev_q = 12'sh000;
    logic [15:0] spd_q = 16'h0000;
    logic fwd_q = 1'b0;
    logic [9:0] asp, apv, fsp, fpv;
    logic signed [11:0] fdev;
    logic [15:0] nspd, speed_cmd;
    logic fwd, pid_active, irq;
    logic [2:0] out_terminals;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] r;
    logic e;
    logic [15:0] s0, smax;

    always #20 pclk = ~pclk; // 25 MHz

    pid_field_model pid_field_model_i (.pclk(pclk), .presetn(presetn),
        .sp_req(sp_q), .pv_req(pv_q), .fsp_req(fsp_q), .fpv_req(fpv_q),
        .dev_req(dev_q), .spd_req(spd_q), .fwd_req(fwd_q),
        .analog_setpoint(asp), .analog_measured(apv), .fb_setpoint(fsp),
        .fb_measured(fpv), .fb_deviation(fdev), .normal_speed(nspd),
        .run_forward(fwd));

    pid_speed_regulator #(.N_IN(7), .N_OUT(3), .SAMPLE_CYC(SC))
        pid_speed_regulator_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_terminals(in_terminals), .analog_setpoint(asp),
        .analog_measured(apv), .fb_setpoint(fsp), .fb_measured(fpv),
        .fb_deviation(fdev), .normal_speed(nspd), .run_forward(fwd),
        .out_terminals(out_terminals), .speed_cmd(speed_cmd),
        .pid_active(pid_active), .irq(irq));

    // Counts, verdict and end of run, reached from every path
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until the rising edge that
    // samples pready high, takes data there, then releases
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Values read right at the edge are the ones that edge sampled
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            check("pready wait", 32'h0, 32'h1);
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, r, e);
        check("register read", r, exp);
    endtask

    // Flags and outputs follow their cause after a fixed register stage;
    // the fourth edge sees what the third one launched
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    // Mode change, then several loop periods before the speed is read
    task automatic mode_speed(input logic [7:0] act, input logic [15:0] exp);
        wr(pid_pkg::ACT_OFS, {24'h0, act});
        repeat (3 * SC + 1) @(posedge pclk);
        check("speed_cmd", {16'h0, speed_cmd}, {16'h0, exp});
    endtask

    initial begin
        logic [7:0] codes [8];
        logic act_exp [8];
        codes = '{8'h14, 8'h15, 8'h32, 8'h33, 8'h3C, 8'h3D, 8'h16, 8'h00};
        act_exp = '{1, 1, 1, 1, 1, 1, 0, 0};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then an unmapped place
        rdchk(pid_pkg::ACT_OFS, 32'h0);
        rdchk(pid_pkg::SETP_OFS, 32'h270F);
        rdchk(pid_pkg::UPLIM_OFS, 32'h270F);
        rdchk(pid_pkg::LOLIM_OFS, 32'h270F);
        rdchk(pid_pkg::GAIN_OFS, 32'h0);
        apb(1'b1, 8'h80, 32'h55, r, e);
        check("slverr write", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h80, 32'h0, r, e);
        check("slverr read", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        // Loop off: plain speed passes through
        spd_q <= 16'h1234;
        settle();
        check("speed plain", {16'h0, speed_cmd}, 32'h1234);
        // Every valid code enables the loop, others do not; mask is clear
        for (int i = 0; i < 8; i++) begin
            wr(pid_pkg::ACT_OFS, {24'h0, codes[i]});
            settle();
            check("active", {31'h0, pid_active}, 32'(act_exp[i]));
            check("irq masked", {31'h0, irq}, 32'h0);
        end
        // Unmasked loop start raises irq; reading status clears it
        rdchk(pid_pkg::IRQST_OFS, 32'h1);
        wr(pid_pkg::IRQMSK_OFS, 32'h1);
        wr(pid_pkg::ACT_OFS, 32'h14);
        settle();
        check("irq set", {31'h0, irq}, 32'h1);
        rdchk(pid_pkg::IRQST_OFS, 32'h1);
        settle();
        check("irq cleared", {31'h0, irq}, 32'h0);
        // Proportional only, gain 2, both actions
        wr(pid_pkg::GAIN_OFS, 32'h2);
        wr(pid_pkg::SETP_OFS, 32'd600);
        pv_q <= 10'd500;
        mode_speed(8'h14, 16'd200);
        mode_speed(8'h15, 16'd0);
        pv_q <= 10'd700;
        mode_speed(8'h15, 16'd200);
        mode_speed(8'h14, 16'd0);
        // Analog set point when the parameter says function off
        wr(pid_pkg::SETP_OFS, 32'h270F);
        sp_q <= 10'd550;
        pv_q <= 10'd500;
        mode_speed(8'h14, 16'd100);
        // Fieldbus deviation, then fieldbus set point and measured value
        dev_q <= 12'sd30;
        mode_speed(8'h32, 16'd60);
        mode_speed(8'h33, 16'd0);
        fsp_q <= 10'd700;
        fpv_q <= 10'd650;
        mode_speed(8'h3C, 16'd100);
        mode_speed(8'h3D, 16'd0);
        // Integral only, from a cleared accumulator: ki*dev per period;
        // speed lags the accumulator by one period, so 3 ticks give 20
        wr(pid_pkg::GAIN_OFS, 32'h100);
        sp_q <= 10'd510;
        wr(pid_pkg::ACT_OFS, 32'h0);
        mode_speed(8'h14, 16'd20);
        s0 = speed_cmd;
        repeat (SC) @(posedge pclk);
        check("integral step", {16'h0, speed_cmd - s0}, 32'd10);
        // Derivative only: a step of deviation gives one pulse
        wr(pid_pkg::GAIN_OFS, 32'h10000);
        sp_q <= 10'd500;
        // Leave the loop first so no integral is left over
        wr(pid_pkg::ACT_OFS, 32'h0);
        mode_speed(8'h14, 16'd0);
        pv_q <= 10'd450;
        smax = 16'h0;
        for (int i = 0; i < 3 * SC; i++) begin
            @(posedge pclk);
            if (speed_cmd > smax)
                smax = speed_cmd;
        end
        check("deriv peak", {16'h0, smax}, 32'd50);
        check("deriv after", {16'h0, speed_cmd}, 32'd0);
        // Loop-select on input slot 3, from the pin and from the network
        wr(pid_pkg::INFN_OFS + 8'h0C, 32'd14);
        settle();
        check("sel off", {31'h0, pid_active}, 32'h0);
        check("sel speed", {16'h0, speed_cmd}, 32'h1234);
        in_terminals <= 7'h08;
        settle();
        check("sel pin", {31'h0, pid_active}, 32'h1);
        in_terminals <= 7'h00;
        wr(pid_pkg::NETIN_OFS, 32'h8);
        settle();
        check("sel net", {31'h0, pid_active}, 32'h1);
        wr(pid_pkg::NETIN_OFS, 32'h0);
        wr(pid_pkg::INFN_OFS + 8'h0C, 32'h0);
        // Outputs: upper, inverted lower, direction
        wr(pid_pkg::OUTFN_OFS, 32'd15);
        wr(pid_pkg::OUTFN_OFS + 8'h04, 32'd114);
        wr(pid_pkg::OUTFN_OFS + 8'h08, 32'd16);
        wr(pid_pkg::UPLIM_OFS, 32'd800);
        wr(pid_pkg::LOLIM_OFS, 32'd200);
        pv_q <= 10'd900;
        fwd_q <= 1'b1;
        settle();
        check("outs high", {29'h0, out_terminals}, 32'h7);
        pv_q <= 10'd100;
        fwd_q <= 1'b0;
        settle();
        check("outs low", {29'h0, out_terminals}, 32'h0);
        wr(pid_pkg::ACT_OFS, 32'h32);
        settle();
        check("outs mode 50", {29'h0, out_terminals}, 32'h2);
        wr(pid_pkg::ACT_OFS, 32'h14);
        wr(pid_pkg::UPLIM_OFS, 32'h270F);
        pv_q <= 10'd900;
        settle();
        check("upper off", {29'h0, out_terminals}, 32'h2);
        wr(pid_pkg::OUTFN_OFS, 32'd47);
        settle();
        check("active out", {29'h0, out_terminals}, 32'h3);
        wr(pid_pkg::OUTFN_OFS, 32'd147);
        settle();
        check("active inv", {29'h0, out_terminals}, 32'h2);
        stop_test();
    end
endmodule
